/* bax_cfg.svh */
`ifndef BAX_CFG_SVH
`define BAX_CFG_SVH

// ============================================================
// Register port map
`define BAX_FILE_LAST 8'h7f
`define BAX_ADDR_ACC 8'h80
`define BAX_ADDR_FLAGS 8'h81
`define BAX_ADDR_PC_LO 8'h82
`define BAX_ADDR_PC_HI 8'h83
`define BAX_ADDR_STATE 8'h84

// ============================================================
// Field positions and widths
`define BAX_FLAG_CARRY 0
`define BAX_FLAG_NIBBLE 1
`define BAX_FLAG_ZERO 2
`define BAX_PC_W 15
`define BAX_PC_HI_W 7
`define BAX_FILE_DEPTH 128

// ============================================================
// Reset values and the counter step
`define BAX_ACC_RST 8'h00
`define BAX_PC_RST 15'h0000
`define BAX_PC_STEP 15'h0001

`endif

/* bax_pkg.sv */
`default_nettype none
package bax_pkg;

    typedef enum logic [2:0] {
        BAX_OP_NOP = 3'h0,
        BAX_OP_ADD = 3'h1,
        BAX_OP_ADDC = 3'h2,
        BAX_OP_ASR = 3'h3,
        BAX_OP_BCLR = 3'h4,
        BAX_OP_BTSC = 3'h5,
        BAX_OP_JUMP = 3'h6
    } bax_op_e;

    typedef enum logic [2:0] {
        BAX_ST_RUN = 3'h1,
        BAX_ST_SKIP = 3'h2,
        BAX_ST_FLUSH = 3'h4
    } bax_state_e;

    typedef struct packed {
        bax_op_e op;
        logic [6:0] faddr;
        logic dest;
        logic [2:0] bitpos;
        logic [8:0] offset;
    } bax_instr_s;

    typedef struct packed {
        logic zero;
        logic nibble_carry_flag;
        logic carry;
    } bax_flags_s;

endpackage
`default_nettype wire

/* bax_add8.sv */
`default_nettype none
module bax_add8 (
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    output logic [7:0] sum,
    output logic cout,
    output logic nibble_cout
);

    logic [4:0] low;
    logic [4:0] high;

    // ============================================================
    // Split at the nibble so the bit 3 carry comes out directly
    always_comb begin
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        high = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, low[4]};
        sum = {high[3:0], low[3:0]};
        cout = high[4];
        nibble_cout = low[4];
    end

endmodule // bax_add8
`default_nettype wire

/* bax_core.sv */
// Implementation choices: the plain strobed port and the address map.
`include "bax_cfg.svh"
`default_nettype none
module bax_core (
    input wire logic clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire bax_pkg::bax_instr_s instr,
    output logic instr_ready,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic [7:0] acc,
    output bax_pkg::bax_flags_s flags,
    output logic [`BAX_PC_W-1:0] pc,
    output logic retire,
    output logic discard
);

    // ============================================================
    // Helpers
    function automatic logic [7:0] bit_mask(input logic [2:0] pos);
        bit_mask = 8'h01 << pos;
    endfunction

    function automatic logic is_file_addr(input logic [7:0] a);
        is_file_addr = (a <= `BAX_FILE_LAST);
    endfunction

    // Flag bits follow the port layout, which matches the packed struct order
    function automatic logic [7:0] flags_to_byte(
        input bax_pkg::bax_flags_s f
    );
        flags_to_byte = 8'h00;
        flags_to_byte[`BAX_FLAG_CARRY] = f.carry;
        flags_to_byte[`BAX_FLAG_NIBBLE] = f.nibble_carry_flag;
        flags_to_byte[`BAX_FLAG_ZERO] = f.zero;
    endfunction

    function automatic bax_pkg::bax_flags_s flags_from_byte(
        input logic [7:0] b
    );
        flags_from_byte.carry = b[`BAX_FLAG_CARRY];
        flags_from_byte.nibble_carry_flag = b[`BAX_FLAG_NIBBLE];
        flags_from_byte.zero = b[`BAX_FLAG_ZERO];
    endfunction

    // ============================================================
    // State
    logic [7:0] file_mem [0:`BAX_FILE_DEPTH-1];
    logic [7:0] acc_r;
    logic [7:0] acc_nxt;
    bax_pkg::bax_flags_s flags_r;
    bax_pkg::bax_flags_s flags_nxt;
    logic [`BAX_PC_W-1:0] pc_r;
    logic [`BAX_PC_W-1:0] pc_nxt;
    bax_pkg::bax_state_e state_r;
    bax_pkg::bax_state_e state_nxt;
    bax_pkg::bax_op_e last_op_r;
    bax_pkg::bax_op_e last_op_nxt;
    logic retire_r;
    logic retire_nxt;
    logic discard_r;
    logic discard_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    logic mem_we;
    logic [6:0] mem_waddr;
    logic [7:0] mem_wdata;

    logic take;
    logic [7:0] fval;
    logic [7:0] sum;
    logic add_cout;
    logic add_nibble;
    logic add_cin;
    logic [7:0] result;
    logic [`BAX_PC_W-1:0] pc_inc;
    logic [`BAX_PC_W-1:0] jump_ofs;

    // ============================================================
    // Datapath
    assign fval = file_mem[instr.faddr];
    assign take = instr_valid && instr_ready;
    assign pc_inc = pc_r + `BAX_PC_STEP;
    assign jump_ofs = {{(`BAX_PC_W-9){instr.offset[8]}}, instr.offset};
    // Plain add never sees the old carry
    assign add_cin = (instr.op == bax_pkg::BAX_OP_ADDC) && flags_r.carry;

    bax_add8 u_add (
        .a(acc_r),
        .b(fval),
        .cin(add_cin),
        .sum(sum),
        .cout(add_cout),
        .nibble_cout(add_nibble)
    );

    // ============================================================
    // Sequencer
    // The flush cycle stalls the source for one cycle; a word
    // still offered after it is taken and executed normally.
    always_comb begin
        instr_ready = (state_r != bax_pkg::BAX_ST_FLUSH);
    end

    // ============================================================
    // Next state
    always_comb begin
        acc_nxt = acc_r;
        flags_nxt = flags_r;
        pc_nxt = pc_r;
        state_nxt = state_r;
        last_op_nxt = last_op_r;
        mem_we = 1'b0;
        mem_waddr = reg_addr[6:0];
        mem_wdata = reg_wdata;
        result = 8'h00;

        // Software writes first; an instruction in the same
        // cycle overrides it, and its file write replaces any port file write.
        if (reg_wr) begin
            if (is_file_addr(reg_addr)) begin
                mem_we = 1'b1;
            end else begin
                case (reg_addr)
                    `BAX_ADDR_ACC: begin
                        acc_nxt = reg_wdata;
                    end
                    `BAX_ADDR_FLAGS: begin
                        flags_nxt = flags_from_byte(reg_wdata);
                    end
                    `BAX_ADDR_PC_LO: begin
                        pc_nxt[7:0] = reg_wdata;
                    end
                    `BAX_ADDR_PC_HI: begin
                        pc_nxt[`BAX_PC_W-1:8] =
                            reg_wdata[`BAX_PC_HI_W-1:0];
                    end
                    default: begin
                    end
                endcase
            end
        end

        case (state_r)
            bax_pkg::BAX_ST_RUN: begin
                if (take) begin
                    pc_nxt = pc_inc;
                    last_op_nxt = instr.op;
                    case (instr.op)
                        bax_pkg::BAX_OP_ADD,
                        bax_pkg::BAX_OP_ADDC: begin
                            result = sum;
                            flags_nxt.carry = add_cout;
                            flags_nxt.nibble_carry_flag = add_nibble;
                            flags_nxt.zero = (sum == 8'h00);
                            if (instr.dest) begin
                                mem_we = 1'b1;
                                mem_waddr = instr.faddr;
                                mem_wdata = result;
                            end else begin
                                acc_nxt = result;
                            end
                        end
                        bax_pkg::BAX_OP_ASR: begin
                            result = {fval[7], fval[7:1]};
                            flags_nxt.carry = fval[0];
                            flags_nxt.zero = (result == 8'h00);
                            if (instr.dest) begin
                                mem_we = 1'b1;
                                mem_waddr = instr.faddr;
                                mem_wdata = result;
                            end else begin
                                acc_nxt = result;
                            end
                        end
                        bax_pkg::BAX_OP_BCLR: begin
                            result = fval & ~bit_mask(instr.bitpos);
                            mem_we = 1'b1;
                            mem_waddr = instr.faddr;
                            mem_wdata = result;
                        end
                        bax_pkg::BAX_OP_BTSC: begin
                            if ((fval & bit_mask(instr.bitpos)) == 8'h00) begin
                                state_nxt = bax_pkg::BAX_ST_SKIP;
                            end
                        end
                        bax_pkg::BAX_OP_JUMP: begin
                            pc_nxt = pc_inc + jump_ofs;
                            state_nxt = bax_pkg::BAX_ST_FLUSH;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            bax_pkg::BAX_ST_SKIP: begin
                // Word consumed as a no-op: only the counter moves
                if (take) begin
                    pc_nxt = pc_inc;
                    state_nxt = bax_pkg::BAX_ST_RUN;
                end
            end
            bax_pkg::BAX_ST_FLUSH: begin
                state_nxt = bax_pkg::BAX_ST_RUN;
            end
            default: begin
                state_nxt = bax_pkg::BAX_ST_RUN;
            end
        endcase
    end

    // ============================================================
    // Register read port
    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_rd) begin
            if (is_file_addr(reg_addr)) begin
                rdata_nxt = file_mem[reg_addr[6:0]];
            end else begin
                case (reg_addr)
                    `BAX_ADDR_ACC: begin
                        rdata_nxt = acc_r;
                    end
                    `BAX_ADDR_FLAGS: begin
                        rdata_nxt = flags_to_byte(flags_r);
                    end
                    `BAX_ADDR_PC_LO: begin
                        rdata_nxt = pc_r[7:0];
                    end
                    `BAX_ADDR_PC_HI: begin
                        rdata_nxt = {1'b0, pc_r[`BAX_PC_W-1:8]};
                    end
                    `BAX_ADDR_STATE: begin
                        rdata_nxt = {2'h0, last_op_r, state_r};
                    end
                    default: begin
                        rdata_nxt = 8'h00;
                    end
                endcase
            end
        end
    end

    // ============================================================
    // Registers
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_r <= `BAX_ACC_RST;
            flags_r <= '0;
            pc_r <= `BAX_PC_RST;
            state_r <= bax_pkg::BAX_ST_RUN;
            last_op_r <= bax_pkg::BAX_OP_NOP;
        end else begin
            acc_r <= acc_nxt;
            flags_r <= flags_nxt;
            pc_r <= pc_nxt;
            state_r <= state_nxt;
            last_op_r <= last_op_nxt;
        end
    end

    // ============================================================
    // Completion pulses
    always_comb begin
        retire_nxt = take && (state_r == bax_pkg::BAX_ST_RUN);
        discard_nxt = take && (state_r == bax_pkg::BAX_ST_SKIP);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            retire_r <= 1'b0;
            discard_r <= 1'b0;
        end else begin
            retire_r <= retire_nxt;
            discard_r <= discard_nxt;
        end
    end

    // ============================================================
    // Read data
    // Zero outside the answer cycle so stale bytes never linger
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // File contents are data, not control, so they carry no reset
    always_ff @(posedge clk) begin
        if (mem_we) begin
            file_mem[mem_waddr] <= mem_wdata;
        end
    end

    // ============================================================
    // Outputs
    assign acc = acc_r;
    assign flags = flags_r;
    assign pc = pc_r;
    assign retire = retire_r;
    assign discard = discard_r;
    assign reg_rdata = rdata_r;

endmodule // bax_core
`default_nettype wire

/* bax_core_properties.sv */
`default_nettype none
module bax_core_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire bax_pkg::bax_instr_s instr,
    input wire logic instr_ready,
    input wire logic reg_wr,
    input wire logic [7:0] acc,
    input wire bax_pkg::bax_flags_s flags,
    input wire logic [14:0] pc,
    input wire logic retire,
    input wire logic discard
);
    // ============================================================
    // Helpers
    // Port writes in the same cycle are left out: their winner is a choice
    logic go, jmp, alu;
    logic [14:0] tgt;
    assign go = instr_valid && instr_ready && !reg_wr;
    assign jmp = go && instr.op == bax_pkg::BAX_OP_JUMP;
    assign alu = go && (instr.op == bax_pkg::BAX_OP_ADD ||
        instr.op == bax_pkg::BAX_OP_ADDC || instr.op == bax_pkg::BAX_OP_ASR);
    assign tgt = pc + 15'h0001 + {{6{instr.offset[8]}}, instr.offset};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_gap;
        !instr_ready ##1 instr_ready;
    endsequence
    // ============================================================
    // Properties
    // A jump that lands as a skipped word shows discard instead
    a_jump_target: assert property (
        jmp |=> discard || pc == $past(tgt))
        else $error("jump target wrong");
    a_jump_gap: assert property (
        jmp |=> (discard or s_gap))
        else $error("jump not two cycles");
    a_jump_flags: assert property (
        jmp |=> $stable(flags)) else $error("jump changed flags");
    a_clear_flags: assert property (
        go && instr.op == bax_pkg::BAX_OP_BCLR |=> $stable(flags))
        else $error("bit clear changed flags");
    a_pc_step: assert property (
        go && !(instr.op == bax_pkg::BAX_OP_JUMP)
        |=> pc == $past(pc) + 15'h0001) else $error("pc step wrong");
    a_zero_flag: assert property (
        alu && !instr.dest |=> discard || flags.zero == (acc == 8'h00))
        else $error("zero flag wrong");
    a_dest_file: assert property (
        alu && instr.dest |=> $stable(acc))
        else $error("file destination touched acc");
    a_shift_nibble: assert property (
        go && instr.op == bax_pkg::BAX_OP_ASR
        |=> $stable(flags.nibble_carry_flag))
        else $error("shift changed nibble carry");
    a_discard_quiet: assert property (
        discard && !$past(reg_wr) |-> $stable(acc) && $stable(flags))
        else $error("discarded word had effects");
    a_retire_one: assert property (
        go |=> retire != discard) else $error("retire or discard missing");
endmodule // bax_core_properties

bind bax_core bax_core_properties bax_core_properties_i (
    .clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .reg_wr(reg_wr), .acc(acc),
    .flags(flags), .pc(pc), .retire(retire), .discard(discard)
);
`default_nettype wire

/* bax_core_tb.sv */
`default_nettype none
module bax_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ============================================================
    // Signals
    logic clk = 1'b0, rst = 1'b1, instr_valid = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    bax_pkg::bax_instr_s instr = '0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, acc;
    logic [14:0] pc, q;
    bax_pkg::bax_flags_s flags;
    logic instr_ready, retire, discard;
    int fail_count = 0, checks_done = 0;
    always #20 clk = ~clk;
    bax_core bax_core_i (.clk(clk), .rst(rst), .instr_valid(instr_valid),
        .instr(instr), .instr_ready(instr_ready), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .acc(acc), .flags(flags), .pc(pc),
        .retire(retire), .discard(discard));
    // ============================================================
    // Bus and instruction tasks
    task automatic chk(logic [14:0] s, logic [14:0] e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    // Port writes never overlap an instruction: the file write would be lost
    task automatic ex(bax_pkg::bax_op_e o, logic [6:0] f, logic d,
        logic [2:0] b, logic [8:0] k);
        @(posedge clk);
        instr <= '{o, f, d, b, k};
        instr_valid <= 1'b1;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
    endtask
    // ============================================================
    // Scenarios
    task automatic t_add;
        wr(8'h05, 8'h0f);
        wr(8'h80, 8'h01);
        ex(bax_pkg::BAX_OP_ADD, 7'h05, 1'b0, 3'h0, 9'h000);
        chk(acc, 8'h10);
        chk(flags, 3'h2);
        wr(8'h05, 8'hf0);
        ex(bax_pkg::BAX_OP_ADD, 7'h05, 1'b1, 3'h0, 9'h000);
        chk(flags, 3'h5);
        rd(8'h05, 8'h00);
        chk(acc, 8'h10);
    endtask
    task automatic t_addc;
        wr(8'h06, 8'h2f);
        ex(bax_pkg::BAX_OP_ADDC, 7'h06, 1'b0, 3'h0, 9'h000);
        chk(acc, 8'h40);
        chk(flags, 3'h2);
    endtask
    task automatic t_asr;
        wr(8'h07, 8'h81);
        ex(bax_pkg::BAX_OP_ASR, 7'h07, 1'b1, 3'h0, 9'h000);
        chk(flags, 3'h3);
        rd(8'h07, 8'hc0);
        chk(acc, 8'h40);
        wr(8'h08, 8'h01);
        ex(bax_pkg::BAX_OP_ASR, 7'h08, 1'b0, 3'h0, 9'h000);
        chk(acc, 8'h00);
        chk(flags, 3'h7);
    endtask
    task automatic t_bclr;
        wr(8'h09, 8'hff);
        for (int i = 0; i < 8; i++) begin
            ex(bax_pkg::BAX_OP_BCLR, 7'h09, 1'b0, i[2:0], 9'h000);
            rd(8'h09, 8'(8'hff << (i + 1)));
        end
        chk(flags, 3'h7);
    endtask
    task automatic t_skip;
        wr(8'h80, 8'h00);
        wr(8'h0a, 8'h04);
        ex(bax_pkg::BAX_OP_BTSC, 7'h0a, 1'b0, 3'h2, 9'h000);
        ex(bax_pkg::BAX_OP_ADD, 7'h0a, 1'b0, 3'h0, 9'h000);
        chk(retire, 1'b1);
        chk(acc, 8'h04);
        q = pc;
        ex(bax_pkg::BAX_OP_BTSC, 7'h0a, 1'b0, 3'h3, 9'h000);
        ex(bax_pkg::BAX_OP_ADD, 7'h0a, 1'b1, 3'h0, 9'h000);
        chk(discard, 1'b1);
        chk(pc, q + 15'h0002);
        chk(acc, 8'h04);
        chk(flags, 3'h0);
        rd(8'h0a, 8'h04);
    endtask
    task automatic t_jump;
        q = pc;
        ex(bax_pkg::BAX_OP_JUMP, 7'h00, 1'b0, 3'h0, 9'h100);
        chk(pc, q + 15'h0001 - 15'h0100);
        chk(instr_ready, 1'b0);
        q = pc;
        ex(bax_pkg::BAX_OP_JUMP, 7'h00, 1'b0, 3'h0, 9'h0ff);
        chk(pc, q + 15'h0100);
        chk(flags, 3'h0);
        rd(8'h90, 8'h00);
        rd(8'h80, 8'h04);
        rd(8'h84, 8'h31);
    endtask
    // ============================================================
    // Run control
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_add;
        t_addc;
        t_asr;
        t_bclr;
        t_skip;
        t_jump;
        wrap_up;
    end
    // The sequence needs about 105 cycles; this leaves wide margin
    initial begin
        #100us;
        fail_count++;
        wrap_up;
    end
endmodule // bax_core_tb
`default_nettype wire
